// ==== hdl/acl_pkg.sv ====
package acl_pkg;
  localparam int ADC_W  = 8;
  localparam int RATE_W = 2;
  localparam int THR_W  = 8;
  localparam int LOW_W  = 6;
  localparam int HIGH_W = 10;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;

  localparam logic [ADDR_W-1:0] ADDR_RAW  = 10'h00e;
  localparam logic [ADDR_W-1:0] ADDR_DEC  = 10'h00f;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 10'h010;
  localparam logic [ADDR_W-1:0] ADDR_THR  = 10'h011;
  localparam logic [ADDR_W-1:0] ADDR_LOW  = 10'h012;
  localparam logic [ADDR_W-1:0] ADDR_HIGH = 10'h013;

  localparam int MODE_BIT = 0;

  localparam logic [ADC_W-1:0]  ADC_RST  = 8'h00;
  localparam logic [THR_W-1:0]  THR_RST  = 8'h1e;
  localparam logic [LOW_W-1:0]  LOW_RST  = 6'h1e;
  localparam logic [HIGH_W-1:0] HIGH_RST = 10'h0c8;
  localparam logic              MODE_RST = 1'b0;

  localparam logic [THR_W-1:0] THR_FLOOR_IN = 8'h00;
  localparam logic [THR_W-1:0] THR_CEIL_IN  = 8'hff;
  localparam logic [THR_W-1:0] THR_MIN      = 8'h01;
  localparam logic [THR_W-1:0] THR_MAX      = 8'hfe;
  localparam logic [LOW_W-1:0] LOW_ZERO     = 6'h00;
  localparam logic [LOW_W-1:0] LOW_MIN      = 6'h01;

  localparam int CLK_PERIOD_NS    = 10;
  localparam int SAMPLE_PERIOD_NS = 10000;
  localparam int SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {LVL_OFF, LVL_LOW, LVL_HIGH} acl_lvl_e;
endpackage : acl_pkg

// ==== hdl/acl_smp_if.sv ====
`timescale 1ns/1ps
interface acl_smp_if #(
  parameter int ADC_W  = 8,
  parameter int RATE_W = 2
);
  logic              tick;
  logic [ADC_W-1:0]  sample;
  logic [RATE_W-1:0] rate_sel;
  logic [ADC_W-1:0]  dec_sample;
  logic              dec_valid;

  modport src (output tick, sample, rate_sel, input dec_sample, dec_valid);
  modport dec (input tick, sample, rate_sel, output dec_sample, dec_valid);
endinterface : acl_smp_if

// ==== hdl/acl_decim.sv ====
`timescale 1ns/1ps
// averages 2**rate_sel consecutive samples
module acl_decim #(
  parameter int ADC_W  = 8,
  parameter int RATE_W = 2
) (
  input wire logic clk,
  input wire logic srst,
  acl_smp_if.dec   bus
);
  localparam int MAXN  = (1 << ((1 << RATE_W) - 1));
  localparam int SUM_W = ADC_W + $clog2(MAXN);

  logic [SUM_W-1:0]  sum_q;
  logic [SUM_W-1:0]  sum_next;
  logic [SUM_W-1:0]  cnt_q;
  logic [SUM_W-1:0]  last_idx;
  logic              window_end;
  logic [ADC_W-1:0]  out_q;
  logic              vld_q;

  assign sum_next   = sum_q + SUM_W'(bus.sample);
  assign last_idx   = SUM_W'((1 << bus.rate_sel) - 1);
  assign window_end = bus.tick && (cnt_q >= last_idx);

  always_ff @(posedge clk) begin
    if (srst) begin
      sum_q <= '0;
      cnt_q <= '0;
      out_q <= '0;
      vld_q <= 1'b0;
    end else begin
      vld_q <= window_end;
      if (window_end) begin
        sum_q <= '0;
        cnt_q <= '0;
        out_q <= ADC_W'(sum_next >> bus.rate_sel);
      end else if (bus.tick) begin
        sum_q <= sum_next;
        cnt_q <= cnt_q + SUM_W'(1);
      end
    end
  end

  assign bus.dec_sample = out_q;
  assign bus.dec_valid  = vld_q;
endmodule : acl_decim

// ==== hdl/acl_top.sv ====
`timescale 1ns/1ps
module acl_top
  import acl_pkg::*;
#(
  parameter int SAMPLE_CYCLES = acl_pkg::SAMPLE_CYCLES
) (
  input  wire logic                          clk,
  input  wire logic                          srst,
  input  wire logic [acl_pkg::ADC_W-1:0]     adc_data,
  input  wire logic [acl_pkg::RATE_W-1:0]    decimation_rate_select,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  input  wire logic [acl_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [acl_pkg::DATA_W-1:0]    reg_wdata,
  output logic      [acl_pkg::DATA_W-1:0]    reg_rdata_q,
  output logic                               reg_rvalid_q,
  output logic                               sink_low_q,
  output logic                               sink_high_q,
  output logic      [acl_pkg::HIGH_W-1:0]    current_sink_pin_q
);
  import acl_pkg::*;

  localparam int DIV_W = $clog2(SAMPLE_CYCLES);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SAMPLE_CYCLES - 1);

  function automatic logic [DATA_W-1:0] zext8(input logic [ADC_W-1:0] v);
    zext8 = DATA_W'(v);
  endfunction : zext8

  // adc pins cross into clk domain
  logic [ADC_W-1:0]  adc_s1_q;
  logic [ADC_W-1:0]  adc_s2_q;
  logic [DIV_W-1:0]  div_q;
  logic              tick_q;
  logic [ADC_W-1:0]  raw_q;
  logic [ADC_W-1:0]  dec_q;
  logic              mode_q;
  logic [THR_W-1:0]  thr_q;
  logic [LOW_W-1:0]  low_q;
  logic [HIGH_W-1:0] high_q;
  acl_lvl_e          lvl_d;

  acl_smp_if #(.ADC_W(ADC_W), .RATE_W(RATE_W)) smp ();

  acl_decim #(.ADC_W(ADC_W), .RATE_W(RATE_W)) u_decim (
    .clk  (clk),
    .srst (srst),
    .bus  (smp.dec)
  );

  assign smp.tick     = tick_q;
  assign smp.sample   = adc_s2_q;
  assign smp.rate_sel = decimation_rate_select;

  always_ff @(posedge clk) begin
    adc_s1_q <= adc_data;
    adc_s2_q <= adc_s1_q;
  end

  // 100 kHz sample strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= (div_q == DIV_LAST) ? '0 : div_q + DIV_W'(1);
      tick_q <= (div_q == DIV_LAST);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      raw_q <= ADC_RST;
      dec_q <= ADC_RST;
    end else begin
      if (tick_q) begin
        raw_q <= adc_s2_q;
      end
      if (smp.dec_valid) begin
        dec_q <= smp.dec_sample;
      end
    end
  end

  // register decode
  logic             wr_ctrl;
  logic             wr_thr;
  logic             wr_low;
  logic             wr_high;
  logic [THR_W-1:0] thr_in;
  logic [THR_W-1:0] thr_clamped;
  logic [LOW_W-1:0] low_in;
  logic [LOW_W-1:0] low_clamped;

  assign wr_ctrl     = reg_wr && (reg_addr == ADDR_CTRL);
  assign wr_thr      = reg_wr && (reg_addr == ADDR_THR);
  assign wr_low      = reg_wr && (reg_addr == ADDR_LOW);
  assign wr_high     = reg_wr && (reg_addr == ADDR_HIGH);
  assign thr_in      = reg_wdata[THR_W-1:0];
  assign low_in      = reg_wdata[LOW_W-1:0];
  assign thr_clamped = (thr_in == THR_FLOOR_IN) ? THR_MIN :
                       (thr_in == THR_CEIL_IN)  ? THR_MAX : thr_in;
  assign low_clamped = (low_in == LOW_ZERO) ? LOW_MIN : low_in;

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q <= MODE_RST;
      thr_q  <= THR_RST;
      low_q  <= LOW_RST;
      high_q <= HIGH_RST;
    end else begin
      if (wr_ctrl) mode_q <= reg_wdata[MODE_BIT];
      if (wr_thr)  thr_q  <= thr_clamped;
      if (wr_low)  low_q  <= low_clamped;
      if (wr_high) high_q <= reg_wdata[HIGH_W-1:0];
    end
  end

  // read mux, reserved bits zero
  logic [DATA_W-1:0] rd_mux;

  assign rd_mux = (reg_addr == ADDR_RAW)  ? zext8(raw_q) :
                  (reg_addr == ADDR_DEC)  ? zext8(dec_q) :
                  (reg_addr == ADDR_CTRL) ? DATA_W'(mode_q) :
                  (reg_addr == ADDR_THR)  ? zext8(thr_q) :
                  (reg_addr == ADDR_LOW)  ? DATA_W'(low_q) :
                  (reg_addr == ADDR_HIGH) ? DATA_W'(high_q) : '0;

  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata_q  <= '0;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) reg_rdata_q <= rd_mux;
    end
  end

  // load current decision
  always_comb begin
    lvl_d = LVL_OFF;
    case (mode_q)
      1'b0: begin
        if (raw_q == ADC_RST)   lvl_d = LVL_OFF;
        else if (raw_q > thr_q) lvl_d = LVL_HIGH;
        else                    lvl_d = LVL_LOW;
      end
      1'b1: begin
        lvl_d = (raw_q == ADC_RST) ? LVL_OFF : LVL_HIGH;
      end
      default: lvl_d = LVL_OFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sink_low_q         <= 1'b0;
      sink_high_q        <= 1'b0;
      current_sink_pin_q <= '0;
    end else begin
      sink_low_q  <= (lvl_d == LVL_LOW);
      sink_high_q <= (lvl_d == LVL_HIGH);
      case (lvl_d)
        LVL_LOW:  current_sink_pin_q <= HIGH_W'(low_q);
        LVL_HIGH: current_sink_pin_q <= high_q;
        default:  current_sink_pin_q <= '0;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_low_mid;
    !mode_q && (raw_q != ADC_RST) && (raw_q <= thr_q);
  endsequence
  sequence s_low_above;
    !mode_q && (raw_q > thr_q);
  endsequence
  sequence s_high_nz;
    mode_q && (raw_q != ADC_RST);
  endsequence

  property p_raw_load;
    tick_q |=> (raw_q == $past(adc_s2_q)) ##1 (!tick_q) [*8];
  endproperty
  a_raw_load: assert property (p_raw_load) else $error("raw sample not refreshed on strobe");

  property p_dec_load;
    smp.dec_valid |=> (dec_q == $past(smp.dec_sample)) && $past(tick_q, 2);
  endproperty
  a_dec_load: assert property (p_dec_load) else $error("decimated sample not captured");

  property p_low_mid;
    s_low_mid |=> sink_low_q && !sink_high_q && (current_sink_pin_q == HIGH_W'($past(low_q)));
  endproperty
  a_low_mid: assert property (p_low_mid) else $error("low code expected below threshold");

  property p_low_above;
    s_low_above |=> sink_high_q && (current_sink_pin_q == $past(high_q));
  endproperty
  a_low_above: assert property (p_low_above) else $error("high code expected above threshold");

  property p_high_nz;
    s_high_nz |=> sink_high_q && !sink_low_q && (current_sink_pin_q == $past(high_q));
  endproperty
  a_high_nz: assert property (p_high_nz) else $error("high idle must drive high code");

  property p_thr_floor;
    (wr_thr && (thr_in == THR_FLOOR_IN)) |=> (thr_q == THR_MIN);
  endproperty
  a_thr_floor: assert property (p_thr_floor) else $error("threshold zero not raised to one");

  property p_thr_ceil;
    (wr_thr && (thr_in == THR_CEIL_IN)) |=> (thr_q == THR_MAX);
  endproperty
  a_thr_ceil: assert property (p_thr_ceil) else $error("threshold ff not capped");

  property p_low_min;
    (wr_low && (low_in == LOW_ZERO)) |=> (low_q == LOW_MIN);
  endproperty
  a_low_min: assert property (p_low_min) else $error("low code zero not raised to one");

  property p_reset_vals;
    $fell(srst) |-> !mode_q && (thr_q == THR_RST) && (low_q == LOW_RST) && (high_q == HIGH_RST);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("wrong values after reset");

  property p_zero_off;
    (raw_q == ADC_RST) |=> !sink_low_q && !sink_high_q && (current_sink_pin_q == '0);
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("zero sample must command no current");

  property p_rsvd_zero;
    reg_rvalid_q |-> (reg_rdata_q[DATA_W-1:HIGH_W] == '0);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved read bits not zero");
endmodule : acl_top

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import acl_pkg::*;

  localparam int SC = 20;

  typedef struct {
    logic [ADC_W-1:0]  adc;
    logic              mode;
    acl_lvl_e          lvl;
    logic [HIGH_W-1:0] code;
  } acl_row_s;

  logic              clk;
  logic              srst;
  logic [ADC_W-1:0]  adc;
  logic [RATE_W-1:0] rsel;
  logic              reg_wr;
  logic              reg_rd;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic              rvalid;
  logic              s_lo;
  logic              s_hi;
  logic [HIGH_W-1:0] code;
  int                failures;
  int                samples_checked;

  // reset values of low and high codes
  acl_row_s rows[7] = '{
    '{8'h00, 1'b0, LVL_OFF,  10'h000},
    '{8'h10, 1'b0, LVL_LOW,  10'h01e},
    '{8'h1e, 1'b0, LVL_LOW,  10'h01e},
    '{8'h1f, 1'b0, LVL_HIGH, 10'h0c8},
    '{8'hff, 1'b0, LVL_HIGH, 10'h0c8},
    '{8'h01, 1'b1, LVL_HIGH, 10'h0c8},
    '{8'h00, 1'b1, LVL_OFF,  10'h000}
  };

  acl_top #(.SAMPLE_CYCLES(SC)) uut (
    .clk                    (clk),
    .srst                   (srst),
    .adc_data               (adc),
    .decimation_rate_select (rsel),
    .reg_wr                 (reg_wr),
    .reg_rd                 (reg_rd),
    .reg_addr               (addr),
    .reg_wdata              (wdata),
    .reg_rdata_q            (rdata),
    .reg_rvalid_q           (rvalid),
    .sink_low_q             (s_lo),
    .sink_high_q            (s_hi),
    .current_sink_pin_q     (code)
  );

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clk);
    #1 reg_wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] e);
    @(posedge clk);
    #1 reg_rd = 1'b1;
    addr = a;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    chk("rvalid", {15'h0, rvalid}, 16'h0001);
    chk("rdata", rdata, e);
    @(posedge clk);
    #1 chk("rvalid_drop", {15'h0, rvalid}, 16'h0000);
  endtask : rd

  task automatic out(input acl_lvl_e l, input logic [HIGH_W-1:0] c);
    chk("sink_low", {15'h0, s_lo}, {15'h0, l == LVL_LOW});
    chk("sink_high", {15'h0, s_hi}, {15'h0, l == LVL_HIGH});
    chk("code", {6'h0, code}, {6'h0, c});
  endtask : out

  // converter input held for three strobes
  task automatic feed(input logic [ADC_W-1:0] v);
    adc = v;
    repeat (3 * SC) @(posedge clk);
    #1;
  endtask : feed

  task automatic print_verdict();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    print_verdict();
  end

  initial begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    addr = '0;
    wdata = '0;
    adc = '0;
    rsel = '0;
    failures = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk);
    #1 srst = 1'b0;
    rd(ADDR_CTRL, 16'h0000);
    rd(ADDR_THR, 16'h001e);
    rd(ADDR_LOW, 16'h001e);
    rd(ADDR_HIGH, 16'h00c8);
    rd(ADDR_RAW, 16'h0000);
    rd(ADDR_DEC, 16'h0000);
    out(LVL_OFF, 10'h000);
    foreach (rows[i]) begin
      wr(ADDR_CTRL, {15'h0, rows[i].mode});
      feed(rows[i].adc);
      rd(ADDR_RAW, {8'h00, rows[i].adc});
      out(rows[i].lvl, rows[i].code);
    end
    wr(ADDR_CTRL, 16'hfffe);
    rd(ADDR_CTRL, 16'h0000);
    wr(ADDR_THR, 16'h0000);
    rd(ADDR_THR, 16'h0001);
    wr(ADDR_THR, 16'hffff);
    rd(ADDR_THR, 16'h00fe);
    wr(ADDR_THR, 16'h1200);
    rd(ADDR_THR, 16'h0001);
    wr(ADDR_LOW, 16'hffc0);
    rd(ADDR_LOW, 16'h0001);
    wr(ADDR_HIGH, 16'hffff);
    rd(ADDR_HIGH, 16'h03ff);
    wr(ADDR_RAW, 16'h00aa);
    rd(ADDR_RAW, 16'h0000);
    rd(10'h3ff, 16'h0000);
    // clamped threshold of one: equal is low, above is high
    feed(8'h01);
    out(LVL_LOW, 10'h001);
    feed(8'h02);
    out(LVL_HIGH, 10'h3ff);
    wr(ADDR_HIGH, 16'h0005);
    repeat (2) @(posedge clk);
    #1;
    out(LVL_HIGH, 10'h005);
    // constant input: every decimation factor averages to itself
    for (int s = 0; s < 4; s++) begin
      rsel = s[1:0];
      adc = 8'h40 + 8'(s);
      repeat ((2 * (1 << s) + 2) * SC) @(posedge clk);
      #1;
      rd(ADDR_DEC, {8'h00, 8'h40 + 8'(s)});
    end
    srst = 1'b1;
    repeat (3) @(posedge clk);
    #1 srst = 1'b0;
    out(LVL_OFF, 10'h000);
    rd(ADDR_THR, 16'h001e);
    rd(ADDR_LOW, 16'h001e);
    rd(ADDR_HIGH, 16'h00c8);
    rd(ADDR_CTRL, 16'h0000);
    print_verdict();
  end
endmodule : tb_top
